// File: logic/energy_detect_channel_assess.sv
`timescale 1ns/10ps
`default_nettype none
module energy_detect_channel_assess #(
   parameter int unsigned RESULT_CYC     = edcca_pkg::RESULT_CYC,
   parameter int unsigned HDR_RESULT_CYC = edcca_pkg::HDR_RESULT_CYC,
   parameter int unsigned SAMPLE_CYC     = edcca_pkg::SAMPLE_CYC
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // Register access
   input  wire edcca_pkg::reg_req_t reg_req,
   output logic [7:0]              reg_rdata_q,
   // Receiver context
   input  wire edcca_pkg::rx_ctx_t rx_ctx,
   input  wire logic [4:0]         rssi,
   input  wire logic               shr_detect,
   input  wire logic               carrier_detect,
   // Completion event
   output logic                    measure_done_interrupt_q
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_AVG,
      ST_PROC
   } meas_state_t;

   meas_state_t state_q;
   meas_state_t state_d;
   logic [15:0] cyc_q;
   logic [15:0] smp_q;
   logic [6:0]  nsmp_q;
   logic [12:0] acc_q;
   logic        hdr_q;
   logic        man_q;
   logic        cca_q;
   logic        cs_seen_q;
   logic [7:0]  energy_level_field_q;
   logic        chan_check_done_q;
   logic        chan_idle_flag_q;
   logic [1:0]  chan_check_mode_q;
   logic [4:0]  channel_q;
   logic [3:0]  threshold_register_q;

   // Decode of host accesses
   wire logic wr_energy = reg_req.wr && (reg_req.addr == edcca_pkg::ADDR_ENERGY);
   wire logic wr_ctrl   = reg_req.wr && (reg_req.addr == edcca_pkg::ADDR_CTRL);
   wire logic wr_thresh = reg_req.wr && (reg_req.addr == edcca_pkg::ADDR_THRESH);
   // Write data fields
   wire logic [1:0] mode_field    = reg_req.wdata[edcca_pkg::CTRL_MODE_LSB +: 2];
   wire logic [4:0] channel_field = reg_req.wdata[4:0];
   wire logic [3:0] thresh_field  = reg_req.wdata[3:0];
   wire logic chan_check_request = wr_ctrl && reg_req.wdata[edcca_pkg::CTRL_REQ_BIT];
   wire logic in_rx     = rx_ctx.in_listen || rx_ctx.in_busy_rx;
   wire logic check_ok  = in_rx && rx_ctx.basic_mode;

   // Start conditions
   wire logic man_go  = wr_energy && in_rx;
   wire logic man_bad = wr_energy && !in_rx;
   wire logic cca_go  = chan_check_request && check_ok;
   wire logic cca_bad = chan_check_request && !check_ok;
   // An automatic start never cuts short a measurement the host asked for
   wire logic host_run = (state_q != ST_IDLE) && (man_q || cca_q);
   wire logic auto_go = shr_detect && !host_run && !man_go && !cca_go;
   wire logic start   = man_go || cca_go || auto_go;

   // Per-sample energy code, 3 dB per signal-strength step
   wire logic [7:0] rssi_ext = {3'h0, rssi - 5'h01};
   wire logic [7:0] smp_code = (rssi == 5'h00) ? 8'h00 : 8'(rssi_ext * edcca_pkg::RSSI_STEP_DB);
   // 64 codes of at most 90 fit the 13-bit sum
   wire logic [12:0] acc_next = acc_q + {5'h00, smp_code};

   wire logic smp_tick  = (state_q == ST_AVG) && (smp_q == 16'(SAMPLE_CYC - 1));
   wire logic [6:0] need = hdr_q ? 7'(edcca_pkg::WIN_HDR_SAMPLES)
                                 : 7'(edcca_pkg::WIN_SAMPLES);
   wire logic last_smp  = smp_tick && (nsmp_q == need - 7'h01);
   wire logic [15:0] end_cyc = hdr_q ? 16'(HDR_RESULT_CYC - 1) : 16'(RESULT_CYC - 1);
   wire logic finish    = (state_q == ST_PROC) && (cyc_q == end_cyc);

   // Average and clamp
   wire logic [12:0] avg = hdr_q ? (acc_q >> edcca_pkg::WIN_HDR_SHIFT)
                                 : (acc_q >> edcca_pkg::WIN_SHIFT);
   wire logic [7:0] ed_code = (avg > {5'h00, edcca_pkg::ENERGY_MAX}) ? edcca_pkg::ENERGY_MAX
                                                                  : avg[7:0];

   // Busy decision
   wire logic [7:0] thr_code   = {3'h0, threshold_register_q, 1'b0};
   wire logic       energy_hit = ed_code > thr_code;
   wire logic       cs_hit     = cs_seen_q || carrier_detect;
   logic            chan_busy;

   always_comb begin
      case (edcca_pkg::chan_check_mode_t'(chan_check_mode_q))
         edcca_pkg::MODE_OR:      chan_busy = cs_hit || energy_hit;
         edcca_pkg::MODE_ENERGY:  chan_busy = energy_hit;
         edcca_pkg::MODE_CARRIER: chan_busy = cs_hit;
         edcca_pkg::MODE_AND:     chan_busy = cs_hit && energy_hit;
         default:                 chan_busy = 1'b1;
      endcase
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ST_AVG;
            end
         end
         ST_AVG: begin
            if (start) begin
               state_d = ST_AVG;
            end else if (last_smp) begin
               state_d = ST_PROC;
            end
         end
         ST_PROC: begin
            if (start) begin
               state_d = ST_AVG;
            end else if (finish) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Measurement sequencer state
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Free-running between measurements; only read while processing
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cyc_q <= 16'h0000;
      end else if (start) begin
         cyc_q <= 16'h0000;
      end else begin
         cyc_q <= cyc_q + 16'h0001;
      end
   end

   // Sample pacing and accumulation
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         smp_q  <= 16'h0000;
         nsmp_q <= 7'h00;
         acc_q  <= 13'h0000;
      end else if (start) begin
         smp_q  <= 16'h0000;
         nsmp_q <= 7'h00;
         acc_q  <= 13'h0000;
      end else begin
         smp_q <= smp_tick ? 16'h0000 : smp_q + 16'h0001;
         if (smp_tick) begin
            acc_q  <= acc_next;
            nsmp_q <= nsmp_q + 7'h01;
         end
      end
   end

   // Kind of the running measurement, latched at its start
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hdr_q <= 1'b0;
         man_q <= 1'b0;
         cca_q <= 1'b0;
      end else if (start) begin
         hdr_q <= auto_go && rx_ctx.high_rate;
         man_q <= man_go;
         cca_q <= cca_go;
      end
   end

   // Carrier seen at any time during a channel check
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cs_seen_q <= 1'b0;
      end else if (start) begin
         cs_seen_q <= 1'b0;
      end else if (state_q != ST_IDLE) begin
         cs_seen_q <= cs_hit;
      end
   end

   // Result register; a host write starts a measurement instead of storing
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         energy_level_field_q <= edcca_pkg::ENERGY_RESET;
      end else if (finish && !start) begin
         energy_level_field_q <= ed_code;
      end
   end

   // Channel-check flags; a fresh request supersedes a completion in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chan_check_done_q <= 1'b0;
         chan_idle_flag_q  <= 1'b0;
      end else if (cca_go) begin
         chan_check_done_q <= 1'b0;
         chan_idle_flag_q  <= 1'b0;
      end else if (cca_bad) begin
         chan_check_done_q <= 1'b1;
         chan_idle_flag_q  <= 1'b0;
      end else if (finish && cca_q) begin
         chan_check_done_q <= 1'b1;
         chan_idle_flag_q  <= !chan_busy;
      end
   end

   // Control and threshold registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chan_check_mode_q    <= edcca_pkg::MODE_RESET;
         channel_q            <= edcca_pkg::CHAN_RESET;
         threshold_register_q <= edcca_pkg::THRESH_RESET;
      end else begin
         if (wr_ctrl) begin
            chan_check_mode_q <= mode_field;
            channel_q         <= channel_field;
         end
         if (wr_thresh) begin
            threshold_register_q <= thresh_field;
         end
      end
   end

   // Shared done event: manual energy or channel check only, never automatic
   wire logic irq_d = man_bad || cca_bad || (finish && !start && (man_q || cca_q));

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         measure_done_interrupt_q <= 1'b0;
      end else begin
         measure_done_interrupt_q <= irq_d;
      end
   end

   // Read data; fields placed by their positions
   logic [7:0] status_rd;
   logic [7:0] ctrl_rd;

   always_comb begin
      status_rd                              = {3'h0, rx_ctx.trx_state};
      status_rd[edcca_pkg::STATUS_DONE_BIT]  = chan_check_done_q;
      status_rd[edcca_pkg::STATUS_IDLE_BIT]  = chan_idle_flag_q;
      // Request bit is never stored, so it always reads back zero
      ctrl_rd                                = {3'h0, channel_q};
      ctrl_rd[edcca_pkg::CTRL_MODE_LSB +: 2] = chan_check_mode_q;
   end

   // Unmapped offsets read zero
   wire logic [7:0] rd_mux =
      (reg_req.addr == edcca_pkg::ADDR_STATUS) ? status_rd :
      (reg_req.addr == edcca_pkg::ADDR_ENERGY) ? energy_level_field_q :
      (reg_req.addr == edcca_pkg::ADDR_CTRL)   ? ctrl_rd :
      (reg_req.addr == edcca_pkg::ADDR_THRESH) ? {4'h0, threshold_register_q} : 8'h00;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_req.rd) begin
         reg_rdata_q <= rd_mux;
      end
   end

endmodule
`default_nettype wire

// File: shared/edcca_pkg.sv
`default_nettype none
package edcca_pkg;
   // Core clock and documented times, in ns
   localparam int CLK_NS        = 4;
   localparam int T_WIN_NS      = 128000;
   localparam int T_WIN_HDR_NS  = 32000;
   localparam int T_RESULT_NS   = 140000;
   localparam int T_SAMPLE_NS   = 2000;
   localparam int SAMPLE_CYC    = T_SAMPLE_NS / CLK_NS;
   localparam int RESULT_CYC    = T_RESULT_NS / CLK_NS;
   localparam int HDR_RESULT_CYC = (T_WIN_HDR_NS + T_RESULT_NS - T_WIN_NS) / CLK_NS;
   localparam int WIN_SAMPLES     = T_WIN_NS / T_SAMPLE_NS;
   localparam int WIN_HDR_SAMPLES = T_WIN_HDR_NS / T_SAMPLE_NS;
   localparam int WIN_SHIFT       = 6;
   localparam int WIN_HDR_SHIFT   = 4;

   // Register offsets
   localparam logic [5:0] ADDR_STATUS = 6'h01;
   localparam logic [5:0] ADDR_ENERGY = 6'h07;
   localparam logic [5:0] ADDR_CTRL   = 6'h08;
   localparam logic [5:0] ADDR_THRESH = 6'h09;

   // Field positions
   localparam int CTRL_REQ_BIT    = 7;
   localparam int CTRL_MODE_LSB   = 5;
   localparam int STATUS_DONE_BIT = 7;
   localparam int STATUS_IDLE_BIT = 6;

   // Reset values and code limits
   localparam logic [7:0] ENERGY_RESET = 8'hff;
   localparam logic [7:0] ENERGY_MAX   = 8'h54;
   localparam logic [1:0] MODE_RESET   = 2'h1;
   localparam logic [4:0] CHAN_RESET   = 5'h00;
   localparam logic [3:0] THRESH_RESET = 4'h0;
   localparam logic [7:0] RSSI_STEP_DB = 8'h03;

   typedef enum logic [1:0] {
      MODE_OR      = 2'h0,
      MODE_ENERGY  = 2'h1,
      MODE_CARRIER = 2'h2,
      MODE_AND     = 2'h3
   } chan_check_mode_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       in_listen;
      logic       in_busy_rx;
      logic       high_rate;
      logic       basic_mode;
      logic [4:0] trx_state;
   } rx_ctx_t;
endpackage
`default_nettype wire

// File: sim/edcca_chk.sv
`timescale 1ns/10ps
`default_nettype none
module edcca_chk #(
   parameter int unsigned RESULT_CYC = 300
) (
   // Clock and reset
   input wire logic                core_clk,
   input wire logic                rst_n,
   // Watched ports
   input wire edcca_pkg::reg_req_t reg_req,
   input wire logic [7:0]          reg_rdata_q,
   input wire edcca_pkg::rx_ctx_t  rx_ctx,
   input wire logic [4:0]          rssi,
   input wire logic                shr_detect,
   input wire logic                carrier_detect,
   input wire logic                measure_done_interrupt_q
);
   logic        in_rx, wr_ed, start, irq, armed_q;
   int unsigned wait_q;
   assign irq = measure_done_interrupt_q;
   assign in_rx = rx_ctx.in_listen | rx_ctx.in_busy_rx;
   assign wr_ed = reg_req.wr && reg_req.addr == edcca_pkg::ADDR_ENERGY;
   assign start = in_rx && (wr_ed || (reg_req.wr && reg_req.addr == edcca_pkg::ADDR_CTRL
                  && reg_req.wdata[7] && rx_ctx.basic_mode));
   // Age of the latest accepted request; a restart rearms it
   always_ff @(posedge core_clk) begin
      wait_q <= start ? 0 : wait_q + 1;
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (start) begin
         armed_q <= 1'b1;
      end else if (irq) begin
         armed_q <= 1'b0;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_ed_start;
      wr_ed && in_rx;
   endsequence
   sequence s_req_then_read;
      start && reg_req.addr == edcca_pkg::ADDR_CTRL
      ##2 reg_req.rd && reg_req.addr == edcca_pkg::ADDR_CTRL;
   endsequence
   AST_RESET_OUT: assert property (disable iff (1'b0) !rst_n |=> reg_rdata_q == 8'h00 && !irq)
      else $error("outputs not cleared in reset");
   AST_IRQ_PULSE: assert property (irq |=> !irq)
      else $error("interrupt longer than one cycle");
   AST_ED_RANGE: assert property (wr_ed == 1'b0 && reg_req.rd && reg_req.addr == 6'h07
      |=> reg_rdata_q <= 8'h54 || reg_rdata_q == 8'hff) else $error("energy code out of range");
   AST_OUTSIDE_IRQ: assert property (wr_ed && !in_rx |-> ##[1:2] irq)
      else $error("no interrupt for request outside receive");
   AST_NO_EARLY_IRQ: assert property (s_ed_start |=> !irq [*8])
      else $error("interrupt right after a measurement start");
   AST_RESULT_TIME: assert property (armed_q && irq
      |-> wait_q inside {[RESULT_CYC-1:RESULT_CYC+3]}) else $error("completion at wrong time");
   AST_NO_STRAY_IRQ: assert property (!armed_q && !reg_req.wr |=> !irq)
      else $error("interrupt without a host request");
   AST_STATUS_READ: assert property (reg_req.rd && reg_req.addr == edcca_pkg::ADDR_STATUS
      |=> reg_rdata_q[5:0] == {1'b0, $past(rx_ctx.trx_state)}) else $error("status read wrong");
   AST_REQ_SELF_CLEAR: assert property (s_req_then_read |=> !reg_rdata_q[7])
      else $error("request bit not cleared");
   AST_RDATA_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata_q))
      else $error("read data changed without a read");
endmodule
bind energy_detect_channel_assess edcca_chk #(.RESULT_CYC(RESULT_CYC)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
   .rx_ctx(rx_ctx), .rssi(rssi), .shr_detect(shr_detect), .carrier_detect(carrier_detect),
   .measure_done_interrupt_q(measure_done_interrupt_q));
`default_nettype wire

// File: sim/edcca_host.sv
`timescale 1ns/10ps
`default_nettype none
module edcca_host (
   input  wire logic               core_clk,
   output var edcca_pkg::reg_req_t reg_req,
   input  wire logic [7:0]         reg_rdata_q
);
   initial reg_req = '0;
   // Strobe held through the taking edge; stale data inverted after
   task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      #1;
      reg_req.wr = 1'b0;
      reg_req.wdata = ~d;
   endtask
   task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req.wdata};
      @(posedge core_clk);
      #1;
      reg_req.rd = 1'b0;
      d = reg_rdata_q;
   endtask
endmodule
`default_nettype wire

// File: sim/energy_detect_channel_assess_test.sv
`timescale 1ns/10ps
`default_nettype none
module energy_detect_channel_assess_test;
   localparam int unsigned RC = 300;
   localparam int unsigned HC = 120;
   logic                core_clk = 1'b0;
   logic                rst_n = 1'b0;
   edcca_pkg::reg_req_t reg_req;
   edcca_pkg::rx_ctx_t  rx_ctx;
   logic [7:0]          rdata;
   logic [4:0]          rssi;
   logic                shr, carrier, irq;
   int                  fails = 0;
   int                  n_compared = 0;
   int                  cycles = 0;
   always #2 core_clk = ~core_clk;
   energy_detect_channel_assess #(.RESULT_CYC(RC), .HDR_RESULT_CYC(HC), .SAMPLE_CYC(4)) uut (
      .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_q(rdata),
      .rx_ctx(rx_ctx), .rssi(rssi), .shr_detect(shr), .carrier_detect(carrier),
      .measure_done_interrupt_q(irq));
   edcca_host host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata_q(rdata));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end
   task automatic wait_irq(input int lim, output int n);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask
   task automatic t_reset;
      logic [7:0] d;
      host.read_reg(edcca_pkg::ADDR_ENERGY, d);
      chk("energy reset", d, 16'hff);
      host.read_reg(edcca_pkg::ADDR_STATUS, d);
      chk("status reset", d, 16'h06);
      host.read_reg(edcca_pkg::ADDR_CTRL, d);
      chk("control reset", d, 16'h20);
      host.read_reg(6'h02, d);
      chk("unmapped read", d, 16'h00);
   endtask
   // High rate, listen: manual window stays long; restart drops the first run
   task automatic t_manual;
      int n;
      logic [7:0] d;
      rx_ctx.high_rate = 1'b1;
      rssi = 5'd28;
      host.write_reg(edcca_pkg::ADDR_ENERGY, 8'h00);
      repeat (100) @(posedge core_clk);
      #1 rssi = 5'd10;
      host.write_reg(edcca_pkg::ADDR_ENERGY, 8'h5a);
      wait_irq(RC + 50, n);
      chk("manual latency", 16'(n), 16'(RC));
      @(posedge core_clk);
      #1 chk("irq pulse", 16'(irq), 16'h0);
      host.read_reg(edcca_pkg::ADDR_ENERGY, d);
      chk("manual result", d, 16'h1b);
      rx_ctx.high_rate = 1'b0;
   endtask
   task automatic t_refused;
      int n;
      logic [7:0] d;
      rx_ctx.in_listen = 1'b0;
      host.write_reg(edcca_pkg::ADDR_ENERGY, 8'h33);
      wait_irq(4, n);
      chk("outside irq", 16'(irq), 16'h1);
      rx_ctx.in_listen = 1'b1;
      rx_ctx.basic_mode = 1'b0;
      host.write_reg(edcca_pkg::ADDR_CTRL, 8'ha0);
      wait_irq(4, n);
      chk("refused irq", 16'(irq), 16'h1);
      rx_ctx.basic_mode = 1'b1;
      host.read_reg(edcca_pkg::ADDR_STATUS, d);
      chk("refused status", d, 16'h86);
      host.read_reg(edcca_pkg::ADDR_ENERGY, d);
      chk("energy kept", d, 16'h1b);
   endtask
   task automatic t_auto(input logic hr, input logic [4:0] r, input int w, input logic [7:0] e);
      logic seen;
      logic [7:0] d;
      seen = 1'b0;
      rx_ctx.high_rate = hr;
      rssi = r;
      @(posedge core_clk);
      #1 shr = 1'b1;
      @(posedge core_clk);
      #1 shr = 1'b0;
      repeat (w) begin
         @(posedge core_clk);
         #1 seen = seen | (irq !== 1'b0);
      end
      chk("auto irq", 16'(seen), 16'h0);
      host.read_reg(edcca_pkg::ADDR_ENERGY, d);
      chk("auto result", d, 16'(e));
      rx_ctx.high_rate = 1'b0;
   endtask
   task automatic t_cca;
      int n;
      logic [7:0] d;
      logic busy;
      rssi = 5'd10;
      for (int k = 0; k < 16; k++) begin
         carrier = k[1];
         rx_ctx.in_listen = !k[0];
         rx_ctx.in_busy_rx = k[0];
         // Energy code 27: threshold 13 gives 26 (busy), 14 gives 28
         host.write_reg(edcca_pkg::ADDR_THRESH, k[0] ? 8'h0d : 8'h0e);
         host.write_reg(edcca_pkg::ADDR_CTRL, {1'b1, k[3:2], 5'h00});
         host.read_reg(edcca_pkg::ADDR_CTRL, d);
         chk("request clear", d, 16'({1'b0, k[3:2], 5'h00}));
         host.read_reg(edcca_pkg::ADDR_STATUS, d);
         chk("flags cleared", 16'(d[7:6]), 16'h0);
         wait_irq(RC + 50, n);
         chk("check latency", 16'(n), 16'(RC - 4));
         case (k[3:2])
            2'h0: busy = k[1] | k[0];
            2'h1: busy = k[0];
            2'h2: busy = k[1];
            default: busy = k[1] & k[0];
         endcase
         host.read_reg(edcca_pkg::ADDR_STATUS, d);
         chk("check status", d, 16'({1'b1, !busy, 6'h06}));
      end
      rx_ctx.in_listen = 1'b1;
      rx_ctx.in_busy_rx = 1'b0;
   endtask
   initial begin
      rx_ctx = '{in_listen: 1'b1, in_busy_rx: 1'b0, high_rate: 1'b0, basic_mode: 1'b1,
                 trx_state: 5'h06};
      rssi = 5'd0;
      shr = 1'b0;
      carrier = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_manual();
      t_refused();
      t_auto(1'b0, 5'd28, RC + 20, 8'h51);
      t_auto(1'b1, 5'd4, HC + 3, 8'h09);
      t_cca();
      complete_run();
   end
endmodule
`default_nettype wire
